// ---- hdl/alc_defines.svh ----
// offsets, field positions, reset values and level constants of the level-control input path
`ifndef ALC_DEFINES_SVH
`define ALC_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define ALC_OFS_CTRL 8'h00
`define ALC_OFS_REF 8'h04
`define ALC_OFS_VOL 8'h08
`define ALC_OFS_INPUT 8'h0c
`define ALC_OFS_STATUS 8'h10

// ****************************************
// control and input word fields
// ****************************************
`define ALC_CTRL_EN 0
`define ALC_CTRL_ZCDIS 1
`define ALC_CTRL_THR 3:2
`define ALC_CTRL_ATT 5:4
`define ALC_CTRL_ZTM 7:6
`define ALC_CTRL_WTM 9:8
`define ALC_CTRL_RGAIN 11:10
`define ALC_IN_LSRC 0
`define ALC_IN_RSRC 1
`define ALC_IN_LDIFF 2
`define ALC_IN_RDIFF 3
`define ALC_IN_GAIN 5:4
`define ALC_IN_BIAS 6

// ****************************************
// reset values and codes
// ****************************************
`define ALC_RST_REF 8'he1
`define ALC_RST_VOL 8'h91
`define ALC_RST_GAIN 2'h1
`define ALC_GAIN_BAD 2'h3
`define ALC_VOL_MAX 8'hf1
`define ALC_VOL_MUTE 8'h00
`define ALC_PERIOD_BASE 11'h080
`define ALC_RESP_OKAY 2'h0
`define ALC_RESP_SLVERR 2'h2

// ****************************************
// full-scale magnitudes of -2.5, -4.1, -6.0, -8.5 and -12 dBFS
// ****************************************
`define ALC_LVL_0 16'h5ff3
`define ALC_LVL_1 16'h4fd5
`define ALC_LVL_2 16'h4026
`define ALC_LVL_3 16'h301a
`define ALC_LVL_4 16'h2027

`endif

// ---- hdl/alc_input_path.sv ----
// level-control input path: limiter, recovery, volume codes, input selection and mic bias
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "alc_defines.svh"

module alc_input_path import alc_pkg::*; #(
   parameter int SAMPLE_W = 16,
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic sampleValid,
   input wire logic signed [SAMPLE_W-1:0] sampleLeft,
   input wire logic signed [SAMPLE_W-1:0] sampleRight,
   output logic [7:0] leftVolumeCode,
   output logic [7:0] rightVolumeCode,
   output logic leftSourceSel,
   output logic rightSourceSel,
   output logic leftDiffMode,
   output logic rightDiffMode,
   output logic [1:0] micGainSel,
   output logic micBiasOut
);

   // ****************************************
   // state
   // ****************************************
   alc_state_t s_reg;
   alc_state_t s_next;

   logic [15:0] absLeft;
   logic [15:0] absRight;
   logic [15:0] peak;
   logic [15:0] thrLevel;
   logic [15:0] rstLevel;
   logic overThr;
   logic belowRst;
   logic crossLeft;
   logic crossRight;
   logic pending;
   logic [10:0] zcPeriod;
   logic [10:0] waitPeriod;
   logic zcHit;
   logic [7:0] attAmount;
   logic [7:0] recAmount;
   logic [7:0] attTarget;
   logic [8:0] recSum;
   logic [7:0] recLimit;
   logic [7:0] recTarget;
   logic doWrite;
   logic [31:0] wMerged;
   logic inputLegal;

   function automatic logic [15:0] magnitude(input logic [15:0] x);
      magnitude = x[15] ? 16'(~x + 16'h0001) : x;
   endfunction : magnitude

   function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         lanes[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : lanes

   // ****************************************
   // level detection and step arithmetic
   // ****************************************
   assign absLeft = magnitude(16'(sampleLeft));
   assign absRight = magnitude(16'(sampleRight));
   assign peak = (absLeft > absRight) ? absLeft : absRight;

   always_comb begin
      case (s_reg.thrSel)
         2'h0: begin
            thrLevel = `ALC_LVL_0;
            rstLevel = `ALC_LVL_1;
         end
         2'h1: begin
            thrLevel = `ALC_LVL_1;
            rstLevel = `ALC_LVL_2;
         end
         2'h2: begin
            thrLevel = `ALC_LVL_2;
            rstLevel = `ALC_LVL_3;
         end
         default: begin
            thrLevel = `ALC_LVL_3;
            rstLevel = `ALC_LVL_4;
         end
      endcase
   end

   assign overThr = peak >= thrLevel;
   assign belowRst = peak < rstLevel;
   assign crossLeft = sampleLeft[SAMPLE_W-1] != s_reg.signLeft;
   assign crossRight = sampleRight[SAMPLE_W-1] != s_reg.signRight;
   assign pending = (s_reg.volLeft != s_reg.tgtLeft) || (s_reg.volRight != s_reg.tgtRight);
   assign zcPeriod = `ALC_PERIOD_BASE << s_reg.zcSel;
   assign waitPeriod = `ALC_PERIOD_BASE << s_reg.waitSel;
   assign zcHit = pending && (s_reg.zcCount == 11'(zcPeriod - 11'h001));
   assign attAmount = s_reg.zcDis ? 8'h01 : 8'(8'h01 << s_reg.attStep);
   assign recAmount = 8'(s_reg.recStep) + 8'h01;
   assign attTarget = (s_reg.tgtLeft > attAmount) ? 8'(s_reg.tgtLeft - attAmount) : `ALC_VOL_MUTE;
   assign recSum = 9'(s_reg.tgtLeft) + 9'(recAmount);
   assign recLimit = (s_reg.refLevel > `ALC_VOL_MAX) ? `ALC_VOL_MAX : s_reg.refLevel;
   assign recTarget = (recSum > 9'(recLimit)) ? recLimit : recSum[7:0];

   // ****************************************
   // bus decode
   // ****************************************
   assign doWrite = s_reg.awGot && s_reg.wGot && !s_reg.bValid;
   assign s_axi_awready = !s_reg.awGot && !s_reg.bValid;
   assign s_axi_wready = !s_reg.wGot && !s_reg.bValid;
   assign s_axi_arready = !s_reg.rValid;

   always_comb begin
      wMerged = 32'h0;
      case (s_reg.awAddr)
         `ALC_OFS_CTRL: wMerged = lanes({20'h0, s_reg.recStep, s_reg.waitSel, s_reg.zcSel, s_reg.attStep,
                                         s_reg.thrSel, s_reg.zcDis, s_reg.alcEn}, s_reg.wData, s_reg.wStrb);
         `ALC_OFS_REF: wMerged = lanes({24'h0, s_reg.refLevel}, s_reg.wData, s_reg.wStrb);
         `ALC_OFS_VOL: wMerged = lanes({16'h0, s_reg.manRight, s_reg.manLeft}, s_reg.wData, s_reg.wStrb);
         `ALC_OFS_INPUT: wMerged = lanes({25'h0, s_reg.micBias, s_reg.micGain, s_reg.rightDiff, s_reg.leftDiff,
                                          s_reg.rightSrc, s_reg.leftSrc}, s_reg.wData, s_reg.wStrb);
         default: wMerged = 32'h0;
      endcase
   end

   // a differential pair borrows one pin of the other side, so a select naming that pin has no path
   assign inputLegal = !(!wMerged[`ALC_IN_LDIFF] && wMerged[`ALC_IN_RDIFF] && wMerged[`ALC_IN_LSRC])
      && !(wMerged[`ALC_IN_LDIFF] && !wMerged[`ALC_IN_RDIFF] && !wMerged[`ALC_IN_RSRC])
      && (wMerged[`ALC_IN_GAIN] != `ALC_GAIN_BAD);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      // write channel: address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.awGot = 1'b1;
         s_next.awAddr = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.wGot = 1'b1;
         s_next.wData = s_axi_wdata;
         s_next.wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         s_next.awGot = 1'b0;
         s_next.wGot = 1'b0;
         s_next.bValid = 1'b1;
         s_next.bResp = `ALC_RESP_OKAY;
         case (s_reg.awAddr)
            `ALC_OFS_CTRL: begin
               s_next.alcEn = wMerged[`ALC_CTRL_EN];
               s_next.zcDis = wMerged[`ALC_CTRL_ZCDIS];
               s_next.thrSel = wMerged[`ALC_CTRL_THR];
               s_next.attStep = wMerged[`ALC_CTRL_ATT];
               s_next.zcSel = wMerged[`ALC_CTRL_ZTM];
               s_next.waitSel = wMerged[`ALC_CTRL_WTM];
               s_next.recStep = wMerged[`ALC_CTRL_RGAIN];
            end
            `ALC_OFS_REF: s_next.refLevel = wMerged[7:0];
            `ALC_OFS_VOL: begin
               s_next.manLeft = wMerged[7:0];
               s_next.manRight = wMerged[15:8];
            end
            `ALC_OFS_INPUT: begin
               if (inputLegal) begin
                  s_next.leftSrc = wMerged[`ALC_IN_LSRC];
                  s_next.rightSrc = wMerged[`ALC_IN_RSRC];
                  s_next.leftDiff = wMerged[`ALC_IN_LDIFF];
                  s_next.rightDiff = wMerged[`ALC_IN_RDIFF];
                  s_next.micGain = wMerged[`ALC_IN_GAIN];
                  s_next.micBias = wMerged[`ALC_IN_BIAS];
               end
            end
            `ALC_OFS_STATUS: s_next.bResp = `ALC_RESP_OKAY;
            default: s_next.bResp = `ALC_RESP_SLVERR;
         endcase
      end
      if (s_reg.bValid && s_axi_bready) begin
         s_next.bValid = 1'b0;
      end
      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rValid = 1'b1;
         s_next.rResp = `ALC_RESP_OKAY;
         case (8'(s_axi_araddr))
            `ALC_OFS_CTRL: s_next.rData = {20'h0, s_reg.recStep, s_reg.waitSel, s_reg.zcSel, s_reg.attStep,
                                           s_reg.thrSel, s_reg.zcDis, s_reg.alcEn};
            `ALC_OFS_REF: s_next.rData = {24'h0, s_reg.refLevel};
            `ALC_OFS_VOL: s_next.rData = {16'h0, s_reg.manRight, s_reg.manLeft};
            `ALC_OFS_INPUT: s_next.rData = {25'h0, s_reg.micBias, s_reg.micGain, s_reg.rightDiff, s_reg.leftDiff,
                                            s_reg.rightSrc, s_reg.leftSrc};
            `ALC_OFS_STATUS: s_next.rData = {13'h0, s_reg.mode, s_reg.volRight, s_reg.volLeft};
            default: begin
               s_next.rData = 32'h0;
               s_next.rResp = `ALC_RESP_SLVERR;
            end
         endcase
      end else if (s_reg.rValid && s_axi_rready) begin
         s_next.rValid = 1'b0;
      end
      // level control, once per sample period
      if (sampleValid) begin
         s_next.signLeft = sampleLeft[SAMPLE_W-1];
         s_next.signRight = sampleRight[SAMPLE_W-1];
         if (!s_reg.alcEn) begin
            s_next.mode = ALC_MANUAL;
            s_next.tgtLeft = s_reg.manLeft;
            s_next.tgtRight = s_reg.manRight;
         end else begin
            case (s_reg.mode)
               ALC_MANUAL: begin
                  // both channels start from the left manual code
                  s_next.mode = ALC_RECOVER;
                  s_next.waitCount = 11'h0;
                  s_next.tgtLeft = s_reg.manLeft;
                  s_next.tgtRight = s_reg.manLeft;
               end
               ALC_LIMIT: begin
                  if (overThr) begin
                     if (!pending) begin
                        s_next.tgtLeft = attTarget;
                        s_next.tgtRight = attTarget;
                     end
                  end else begin
                     s_next.mode = ALC_RECOVER;
                     s_next.waitCount = 11'h0;
                  end
               end
               ALC_RECOVER: begin
                  if (overThr) begin
                     s_next.mode = ALC_LIMIT;
                     if (!pending) begin
                        s_next.tgtLeft = attTarget;
                        s_next.tgtRight = attTarget;
                     end
                  end else if (!belowRst) begin
                     s_next.waitCount = 11'h0;
                  end else if (s_reg.waitCount >= 11'(waitPeriod - 11'h001)) begin
                     // an unfinished change holds the wait expired, so a long timeout paces the steps
                     if (!pending) begin
                        s_next.waitCount = 11'h0;
                        if (s_reg.tgtLeft < recLimit) begin
                           s_next.tgtLeft = recTarget;
                           s_next.tgtRight = recTarget;
                        end
                     end
                  end else begin
                     s_next.waitCount = 11'(s_reg.waitCount + 11'h001);
                  end
               end
               default: s_next.mode = ALC_MANUAL;
            endcase
         end
         // apply volume codes
         if (s_reg.alcEn && s_reg.zcDis) begin
            s_next.volLeft = s_next.tgtLeft;
            s_next.volRight = s_next.tgtRight;
         end else begin
            if (crossLeft || zcHit) begin
               s_next.volLeft = s_reg.tgtLeft;
            end
            if (crossRight || zcHit) begin
               s_next.volRight = s_reg.tgtRight;
            end
         end
         if (!pending || zcHit || (s_next.tgtLeft != s_reg.tgtLeft) || (s_next.tgtRight != s_reg.tgtRight)) begin
            s_next.zcCount = 11'h0;
         end else begin
            s_next.zcCount = 11'(s_reg.zcCount + 11'h001);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg <= '{alcEn: 1'b0, zcDis: 1'b0, thrSel: 2'h0, attStep: 2'h0, zcSel: 2'h0, waitSel: 2'h0,
                    recStep: 2'h0, refLevel: `ALC_RST_REF, manLeft: `ALC_RST_VOL, manRight: `ALC_RST_VOL,
                    leftSrc: 1'b0, rightSrc: 1'b0, leftDiff: 1'b0, rightDiff: 1'b0, micGain: `ALC_RST_GAIN,
                    micBias: 1'b0, volLeft: `ALC_RST_VOL, volRight: `ALC_RST_VOL, tgtLeft: `ALC_RST_VOL,
                    tgtRight: `ALC_RST_VOL, signLeft: 1'b0, signRight: 1'b0, zcCount: 11'h0, waitCount: 11'h0,
                    mode: ALC_MANUAL, awGot: 1'b0, wGot: 1'b0, awAddr: 8'h0, wData: 32'h0, wStrb: 4'h0,
                    bValid: 1'b0, bResp: 2'h0, rValid: 1'b0, rData: 32'h0, rResp: 2'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_bvalid = s_reg.bValid;
   assign s_axi_bresp = s_reg.bResp;
   assign s_axi_rvalid = s_reg.rValid;
   assign s_axi_rdata = s_reg.rData;
   assign s_axi_rresp = s_reg.rResp;
   assign leftVolumeCode = s_reg.volLeft;
   assign rightVolumeCode = s_reg.volRight;
   assign leftSourceSel = s_reg.leftSrc;
   assign rightSourceSel = s_reg.rightSrc;
   assign leftDiffMode = s_reg.leftDiff;
   assign rightDiffMode = s_reg.rightDiff;
   assign micGainSel = s_reg.micGain;
   assign micBiasOut = s_reg.micBias;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence limitStep;
      sampleValid && s_reg.alcEn && s_reg.mode == ALC_LIMIT && overThr && !pending;
   endsequence

   sequence recoverStep;
      sampleValid && s_reg.alcEn && s_reg.mode == ALC_RECOVER && belowRst && !pending
         && s_reg.waitCount >= 11'(waitPeriod - 11'h001) && s_reg.tgtLeft < recLimit;
   endsequence

   manual_mode_a: assert property (sampleValid && !s_reg.alcEn |=> s_reg.mode == ALC_MANUAL)
      else $error("level control active while disabled");
   equal_codes_a: assert property (s_reg.mode != ALC_MANUAL && s_reg.alcEn |-> s_reg.tgtLeft == s_reg.tgtRight)
      else $error("channel targets differ under level control");
   atten_amount_a: assert property (limitStep |=> s_reg.tgtLeft == 8'(($past(s_reg.tgtLeft) > $past(attAmount))
      ? $past(s_reg.tgtLeft) - $past(attAmount) : 8'h00))
      else $error("limiter step wrong");
   immediate_apply_a: assert property (sampleValid && s_reg.alcEn && s_reg.zcDis |=> s_reg.volLeft == s_reg.tgtLeft
      && s_reg.volRight == s_reg.tgtRight)
      else $error("volume not applied at once");
   timeout_bound_a: assert property (s_reg.zcCount < zcPeriod)
      else $error("zero-cross timer passed its period");
   cross_apply_a: assert property (sampleValid && crossLeft && !(s_reg.alcEn && s_reg.zcDis)
      |=> s_reg.volLeft == $past(s_reg.tgtLeft))
      else $error("left code not applied at crossing");
   recover_step_a: assert property (recoverStep |=> s_reg.tgtLeft > $past(s_reg.tgtLeft)
      && s_reg.tgtLeft <= $past(recLimit))
      else $error("recovery step wrong");
   ref_cap_a: assert property (s_reg.mode == ALC_RECOVER && s_reg.tgtLeft > $past(s_reg.tgtLeft)
      |-> s_reg.tgtLeft <= s_reg.refLevel)
      else $error("recovery passed the reference");
   wait_reset_a: assert property (sampleValid && s_reg.alcEn && s_reg.mode == ALC_RECOVER && !overThr && !belowRst
      |=> s_reg.waitCount == 11'h0)
      else $error("wait timer not restarted");
   gain_refuse_a: assert property (doWrite && s_reg.awAddr == `ALC_OFS_INPUT && wMerged[`ALC_IN_GAIN] == `ALC_GAIN_BAD
      |=> micGainSel == $past(micGainSel))
      else $error("unavailable gain accepted");
   mute_floor_a: assert property (limitStep ##0 (s_reg.tgtLeft == `ALC_VOL_MUTE) |=> s_reg.tgtLeft == `ALC_VOL_MUTE)
      else $error("volume wrapped below mute");

endmodule : alc_input_path

// ---- hdl/alc_pkg.sv ----
// types shared by the level-control input path
package alc_pkg;

   typedef enum logic [2:0] {
      ALC_MANUAL = 3'b001,
      ALC_LIMIT = 3'b010,
      ALC_RECOVER = 3'b100
   } alc_mode_t;

   typedef struct packed {
      logic alcEn;
      logic zcDis;
      logic [1:0] thrSel;
      logic [1:0] attStep;
      logic [1:0] zcSel;
      logic [1:0] waitSel;
      logic [1:0] recStep;
      logic [7:0] refLevel;
      logic [7:0] manLeft;
      logic [7:0] manRight;
      logic leftSrc;
      logic rightSrc;
      logic leftDiff;
      logic rightDiff;
      logic [1:0] micGain;
      logic micBias;
      logic [7:0] volLeft;
      logic [7:0] volRight;
      logic [7:0] tgtLeft;
      logic [7:0] tgtRight;
      logic signLeft;
      logic signRight;
      logic [10:0] zcCount;
      logic [10:0] waitCount;
      alc_mode_t mode;
      logic awGot;
      logic wGot;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } alc_state_t;

endpackage : alc_pkg

// ---- sim/alc_input_path_test.sv ----
// self-checking bench for the level-control input path
`timescale 1ns/1ps
`include "alc_defines.svh"
module alc_input_path_test;
   logic clk_sys = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, alt = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [15:0] amp = 16'h0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] resp, s_axi_bresp, s_axi_rresp, micGainSel;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sampleValid, micBiasOut;
   logic [31:0] s_axi_rdata;
   logic signed [15:0] sampleLeft, sampleRight;
   logic [7:0] leftVolumeCode, rightVolumeCode;
   logic leftSourceSel, rightSourceSel, leftDiffMode, rightDiffMode;
   int nErrors = 0, numChecks = 0;
   alc_input_path alc_input_path_inst (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .sampleValid, .sampleLeft, .sampleRight, .leftVolumeCode, .rightVolumeCode,
      .leftSourceSel, .rightSourceSel, .leftDiffMode, .rightDiffMode, .micGainSel, .micBiasOut);
   alc_sample_source alc_sample_source_inst (.clk_sys, .reset, .amp, .alt, .sampleValid, .sampleLeft,
      .sampleRight);
   always #5 clk_sys = ~clk_sys;
   task automatic end_of_test();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (i == 50) begin
         nErrors++;
         end_of_test();
      end
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      int i;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (i == 50) begin
         nErrors++;
         end_of_test();
      end
   endtask : rdw
   task automatic t_reset();
      chk("volume after reset", {leftVolumeCode, rightVolumeCode}, 16'h9191);
      chk("gain after reset", micGainSel, 2'h1);
      rdw(`ALC_OFS_REF);
      chk("reference after reset", rd, 32'he1);
      rdw(8'h14);
      chk("unmapped response", resp, `ALC_RESP_SLVERR);
      wr(8'h14, 32'h0);
      chk("unmapped write response", resp, `ALC_RESP_SLVERR);
   endtask : t_reset
   task automatic t_input();
      wr(`ALC_OFS_INPUT, 32'h66);
      cyc(2);
      chk("source and bias", {leftSourceSel, rightSourceSel, leftDiffMode, rightDiffMode, micBiasOut}, 5'h0d);
      chk("gain select", micGainSel, 2'h2);
      // left differential with right input zero, then gain code three: both dropped
      wr(`ALC_OFS_INPUT, 32'h05);
      wr(`ALC_OFS_INPUT, 32'h30);
      rdw(`ALC_OFS_INPUT);
      chk("refused input writes", rd, 32'h66);
      chk("bias output", micBiasOut, 1'b1);
   endtask : t_input
   task automatic t_limit();
      // fields set while level control is off, as software must
      wr(`ALC_OFS_REF, 32'h95);
      amp <= 16'h7000;
      wr(`ALC_OFS_CTRL, 32'h33);
      cyc(40);
      v = leftVolumeCode;
      cyc(32);
      chk("one step per sample", leftVolumeCode, v - 8'h08);
      chk("channels equal", rightVolumeCode, leftVolumeCode);
   endtask : t_limit
   task automatic t_recover();
      int i;
      amp <= 16'h5000;
      cyc(8);
      v = leftVolumeCode;
      cyc(1200);
      chk("reset band holds wait", leftVolumeCode, v);
      amp <= 16'h1000;
      cyc(400);
      chk("no rise before wait", leftVolumeCode, v);
      for (i = 0; i < 20480 && leftVolumeCode !== 8'h95; i++) @(posedge clk_sys);
      if (i == 20480) begin
         nErrors++;
         end_of_test();
      end
      cyc(1200);
      chk("rise stops at reference", leftVolumeCode, 8'h95);
      wr(`ALC_OFS_CTRL, 32'h0);
      cyc(80);
      chk("manual after disable", {leftVolumeCode, rightVolumeCode}, 16'h9191);
   endtask : t_recover
   task automatic t_zero();
      // steady positive input: no crossing, so only the timeout can apply a change
      alt <= 1'b0;
      amp <= 16'h7000;
      cyc(20);
      wr(`ALC_OFS_CTRL, 32'h11);
      cyc(400);
      chk("held until timeout", leftVolumeCode, 8'h91);
      cyc(200);
      chk("two steps at timeout", leftVolumeCode, 8'h8f);
      chk("right follows timeout", rightVolumeCode, 8'h8f);
      rdw(`ALC_OFS_STATUS);
      chk("status mode and codes", rd[18:0], {3'h2, 16'h8f8f});
      // every sample crosses now, so steps land at crossings down to mute
      alt <= 1'b1;
      cyc(1200);
      chk("floor at mute", {leftVolumeCode, rightVolumeCode}, 16'h0000);
   endtask : t_zero
   initial begin
      cyc(10);
      reset <= 1'b0;
      cyc(2);
      t_reset();
      t_input();
      t_limit();
      t_recover();
      t_zero();
      end_of_test();
   end
endmodule : alc_input_path_test

// ---- sim/alc_sample_source.sv ----
// stereo sample source standing in for the microphone front end and converter
`timescale 1ns/1ps
module alc_sample_source #(
   parameter int SAMPLE_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [SAMPLE_W-1:0] amp,
   input wire logic alt,
   output logic sampleValid,
   output logic signed [SAMPLE_W-1:0] sampleLeft,
   output logic signed [SAMPLE_W-1:0] sampleRight
);
   logic [1:0] divReg;
   logic negReg;
   // one sample every four clocks, both channels together
   always_ff @(posedge clk_sys) begin
      divReg <= reset ? 2'h0 : divReg + 2'h1;
      // alt flips the sign each sample, so every sample is a crossing
      negReg <= reset ? 1'b0 : ((divReg == 2'h3) ? (alt & ~negReg) : negReg);
      sampleValid <= !reset && divReg == 2'h3;
      if (divReg == 2'h3) begin
         sampleLeft <= negReg ? -$signed(amp) : $signed(amp);
         sampleRight <= negReg ? -$signed(amp) : $signed(amp);
      end else begin
         // stale data between samples is scrambled so it is never mistaken for valid
         sampleLeft <= ~sampleLeft;
         sampleRight <= ~sampleRight;
      end
   end
endmodule : alc_sample_source
